// ---- hw/mct_top.sv ----
// five-channel compare/capture timer with run, lockstep and AHB-Lite registers
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mct_top #(
  parameter int CNT_W = mct_pkg::CNT_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [mct_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [mct_pkg::DATA_W-1:0] hwdata_in,
  output logic [mct_pkg::DATA_W-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // capture/compare pins, four per channel
  input wire logic [mct_pkg::NUM_CH*4-1:0] pin_in,
  output logic [mct_pkg::NUM_CH*4-1:0] pin_out,
  output logic [mct_pkg::NUM_CH*4-1:0] pin_oe_n_out,
  // interrupt
  output logic irq_out
);
  localparam int NCH = mct_pkg::NUM_CH;
  localparam int NST = NCH * 4;

  if (CNT_W != 16) begin : g_bad_width
    $error("counter width must be 16");
  end

  logic [mct_pkg::ADDR_W-1:0] wr_addr;
  logic [mct_pkg::ADDR_W-1:0] rd_addr;
  logic wr_pend;
  logic wr_word;
  logic rd_pend;
  logic take;
  logic commit;
  logic wr_ok;
  logic wr_in_ch;
  logic [2:0] wr_ch;
  logic [3:0] wr_idx;
  logic [mct_pkg::DATA_W-1:0] rd_data;
  logic [7:0] run_reg;
  logic [7:0] lock_reg;
  logic [NST-1:0] status;
  logic [NST-1:0] enable;
  logic [NST-1:0] events;
  logic [NST-1:0] pin_meta;
  logic [NST-1:0] pin_sync;
  logic [NCH-1:0] run;
  logic [NCH-1:0] lock;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] load;
  logic [NCH-1:0] own_clear;
  logic [NCH-1:0] sync_clear;
  logic [NCH-1:0] io_wr;
  logic [NCH-1:0][3:0] reg_wr;
  logic [NCH-1:0][mct_pkg::CTRL_W-1:0] ctrl;
  logic [NCH-1:0][3:0] init_level;
  logic [NCH-1:0][CNT_W-1:0] counts;
  logic [NCH-1:0][3:0][CNT_W-1:0] ccs;

  // address phase is taken only for a selected, valid, ready transfer
  assign take = hsel_in && hready_in && htrans_in[1];
  assign commit = ce_in && wr_pend;
  // narrower than a word is dropped
  assign wr_ok = commit && wr_word;
  assign wr_in_ch = wr_addr < mct_pkg::ADDR_RUN;
  assign wr_ch = wr_addr[mct_pkg::CH_LSB +: 3];
  assign wr_idx = wr_addr[mct_pkg::REG_LSB +: 4];

  // writes finish without wait; reads wait one cycle so they see a write just before
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend <= 1'b0;
      wr_word <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= '0;
      rd_addr <= '0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      hrdata_out <= '0;
    end else if (ce_in) begin
      wr_pend <= take && hwrite_in;
      rd_pend <= take && !hwrite_in;
      if (take && hwrite_in) begin
        wr_addr <= haddr_in;
        wr_word <= hsize_in == mct_pkg::HSIZE_WORD;
      end
      if (take && !hwrite_in) begin
        rd_addr <= haddr_in;
      end
      hreadyout_out <= !(take && !hwrite_in);
      if (rd_pend) begin
        hrdata_out <= rd_data;
      end
    end
  end

  always_comb begin
    logic [2:0] ch;
    logic [3:0] idx;
    ch = rd_addr[mct_pkg::CH_LSB +: 3];
    idx = rd_addr[mct_pkg::REG_LSB +: 4];
    rd_data = '0;
    // reserved run and lockstep bits read zero
    unique case (rd_addr)
      mct_pkg::ADDR_RUN: rd_data[7:0] = run_reg & mct_pkg::CH_MASK;
      mct_pkg::ADDR_LOCK: rd_data[7:0] = lock_reg & mct_pkg::CH_MASK;
      mct_pkg::ADDR_STATUS: rd_data[NST-1:0] = status;
      mct_pkg::ADDR_ENABLE: rd_data[NST-1:0] = enable;
      default: begin
        if (rd_addr < mct_pkg::ADDR_RUN && int'(ch) < NCH) begin
          if (idx == mct_pkg::IDX_COUNTER) begin
            rd_data[CNT_W-1:0] = counts[ch];
          end else if (idx == mct_pkg::IDX_CTRL) begin
            rd_data[mct_pkg::CTRL_W-1:0] = ctrl[ch];
          end else if (idx == mct_pkg::IDX_IO) begin
            rd_data[3:0] = init_level[ch];
          end else if (idx >= mct_pkg::IDX_CC_A && idx < mct_pkg::IDX_CTRL) begin
            // absent C and D read as zero
            if (mct_pkg::has_cd(int'(ch)) || idx < mct_pkg::IDX_CC_A + 4'h2) begin
              rd_data[CNT_W-1:0] = ccs[ch][2'(idx - mct_pkg::IDX_CC_A)];
            end
          end
        end
      end
    endcase
  end

  // run and lockstep registers hold only the channel bits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_reg <= mct_pkg::RUN_RESET;
      lock_reg <= mct_pkg::RUN_RESET;
    end else if (wr_ok) begin
      if (wr_addr == mct_pkg::ADDR_RUN) run_reg <= hwdata_in[7:0] & mct_pkg::CH_MASK;
      if (wr_addr == mct_pkg::ADDR_LOCK) lock_reg <= hwdata_in[7:0] & mct_pkg::CH_MASK;
    end
  end

  // status flags: a new event beats a clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status <= '0;
      enable <= '0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      if (wr_ok && wr_addr == mct_pkg::ADDR_CLEAR) begin
        status <= (status & ~hwdata_in[NST-1:0]) | events;
      end else begin
        status <= status | events;
      end
      if (wr_ok && wr_addr == mct_pkg::ADDR_ENABLE) enable <= hwdata_in[NST-1:0];
      irq_out <= |(status & enable);
    end
  end

  // pins come from outside the clock domain
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (ce_in) begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam int RP = mct_pkg::run_pos(c);
    localparam bit CD = mct_pkg::has_cd(c);
    logic wr_here;
    assign run[c] = run_reg[RP];
    assign lock[c] = lock_reg[RP];
    assign wr_here = wr_ok && wr_in_ch && int'(wr_ch) == c;
    assign hit[c] = wr_here && wr_idx == mct_pkg::IDX_COUNTER;
    assign io_wr[c] = wr_here && wr_idx == mct_pkg::IDX_IO;
    for (genvar i = 0; i < 4; i++) begin : g_reg
      assign reg_wr[c][i] = wr_here && wr_idx == mct_pkg::IDX_CC_A + 4'(i);
    end
    assign load[c] = hit[c] || (lock[c] && |(hit & lock));
    // sync clear needs lockstep and sync source
    assign sync_clear[c] = lock[c] && |(own_clear & lock)
      && ctrl[c][mct_pkg::CTRL_CLR_LSB +: 3] == mct_pkg::MCT_CLR_SYNC;

    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        ctrl[c] <= '0;
        init_level[c] <= 4'h0;
      end else if (ce_in) begin
        if (wr_here && wr_idx == mct_pkg::IDX_CTRL) ctrl[c] <= hwdata_in[mct_pkg::CTRL_W-1:0];
        if (io_wr[c]) init_level[c] <= hwdata_in[3:0];
      end
    end

    // each channel holds its compare/capture values
    mct_channel #(
      .CNT_W(CNT_W),
      .HAS_CD(CD)
    ) u_ch (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .run_in(run[c]),
      .load_in(load[c]),
      .wdata_in(hwdata_in[CNT_W-1:0]),
      .reg_wr_in(reg_wr[c]),
      .cap_mode_in(ctrl[c][mct_pkg::CTRL_CAP_LSB +: 4]),
      .buf_ac_in(ctrl[c][mct_pkg::CTRL_BUF_AC]),
      .buf_bd_in(ctrl[c][mct_pkg::CTRL_BUF_BD]),
      .clr_sel_in(ctrl[c][mct_pkg::CTRL_CLR_LSB +: 3]),
      .sync_clear_in(sync_clear[c]),
      .io_wr_in(io_wr[c]),
      .init_level_in(hwdata_in[3:0]),
      .pin_in(pin_sync[4*c +: 4]),
      .count_out(counts[c]),
      .cc_out(ccs[c]),
      .event_out(events[4*c +: 4]),
      .own_clear_out(own_clear[c]),
      .pin_out(pin_out[4*c +: 4]),
      .pin_oe_n_out(pin_oe_n_out[4*c +: 4])
    );
  end

  // value A of channel 0 and value D of channel 4 hold all ones after reset
  cc_reset_a: assert property (@(posedge clk_in)
    $fell(rst_in) |-> ccs[0][0] == mct_pkg::CC_RESET && ccs[4][3] == mct_pkg::CC_RESET)
    else $error("compare value not all ones after reset");
  cnt_reset_a: assert property (@(posedge clk_in)
    $fell(rst_in) |-> counts[2] == mct_pkg::CNT_RESET)
    else $error("counter not zero after reset");
  run_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && run[0] && !load[0] && !own_clear[0] && !sync_clear[0]
    |=> counts[0] == $past(counts[0]) + 16'h0001)
    else $error("running counter did not step");
  stop_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !run[3] && !load[3] && !own_clear[3] && !sync_clear[3]
    |=> $stable(counts[3]))
    else $error("stopped counter moved");
  reserved_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    run_reg[5:3] == 3'h0 && lock_reg[5:3] == 3'h0)
    else $error("reserved bit set");
  // narrow writes are dropped; a capture or buffer move may still change values
  narrow_drop_a: assert property (@(posedge clk_in) disable iff (rst_in)
    commit && !wr_word && !(|events)
    |=> $stable(run_reg) && $stable(lock_reg) && $stable(ccs))
    else $error("narrow write took effect");
  sync_preset_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && lock[0] && lock[3] && |(hit & lock) |=> counts[0] == counts[3])
    else $error("lockstep preset diverged");
  sync_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sync_clear[3] && !load[3] |=> counts[3] == mct_pkg::CNT_RESET)
    else $error("lockstep clear missed");
  // independent channel ignores presets of others
  indep_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && !lock[1] && !hit[1] && |hit |=> counts[1] != $past(hwdata_in[CNT_W-1:0])
    || $past(counts[1]) + 16'h0001 == counts[1] || counts[1] == $past(counts[1])
    || counts[1] == mct_pkg::CNT_RESET)
    else $error("independent counter was preset");
  // a lockstep write loads every selected counter
  sync_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && |(hit & lock) |-> (load & lock) == lock)
    else $error("lockstep load incomplete");
  // an event always lands in status, even beside a clear
  status_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && |events |=> (status & $past(events)) == $past(events))
    else $error("event lost from status");
  irq_level_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && |(status & enable) |=> irq_out ##1 (irq_out || !$past(|(status & enable))))
    else $error("interrupt not raised");
  read_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && take && !hwrite_in ##1 ce_in |-> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  write_ready_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && take && hwrite_in |=> hreadyout_out)
    else $error("write inserted a wait state");
  // read data must stand until the next read completes
  read_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !(ce_in && rd_pend) |=> $stable(hrdata_out))
    else $error("read data changed without a read");

  sync_preset_c: cover property (@(posedge clk_in) disable iff (rst_in)
    ce_in && lock[0] && lock[3] && hit[0]);
  sync_clear_c: cover property (@(posedge clk_in) disable iff (rst_in)
    ce_in && sync_clear[3]);
  narrow_c: cover property (@(posedge clk_in) disable iff (rst_in)
    commit && !wr_word);
  irq_c: cover property (@(posedge clk_in) disable iff (rst_in) $rose(irq_out));
  capture_c: cover property (@(posedge clk_in) disable iff (rst_in)
    ce_in && events[0] && ctrl[0][mct_pkg::CTRL_CAP_LSB]);
endmodule // mct_top
`default_nettype wire

// ---- hw/mct_pkg.sv ----
// shared constants, types and helpers of the five-channel compare/capture timer
// Notes on behaviour
// - compare/capture values: 16 bits, compare or capture
// - sixteen values: A-D on 0,3,4; A-B on 1,2
// - C buffers A, D buffers B on 0,3,4
// - whole-word writes only; narrower writes ignored, reads of any size return the whole word
// - compare/capture values reset to all ones
// - run bits 7,6,2,1,0 let channels 4,3,2,1,0 count
// - stopping keeps the compare-driven pin level
// - pin control write while stopped drives initial level
// - bits 5 to 3 read zero, write zero
// - lockstep bits share run bit positions
// - lockstep channels preset together and, with sync clear selected, clear together
// - unselected channels preset and clear independently
// - counters 16 bits, reset to zero
// - capture copies counter; match sets flag
`default_nettype none
package mct_pkg;
  localparam int NUM_CH = 5;
  localparam int CNT_W = 16;
  localparam int NUM_CC = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [15:0] CC_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] RUN_RESET = 8'h00;
  localparam logic [7:0] CH_MASK = 8'hC7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // channel window: channel number in haddr[8:6], register index in haddr[5:2]
  localparam int CH_LSB = 6;
  localparam int REG_LSB = 2;
  localparam logic [3:0] IDX_COUNTER = 4'h0;
  localparam logic [3:0] IDX_CC_A = 4'h1;
  localparam logic [3:0] IDX_CTRL = 4'h5;
  localparam logic [3:0] IDX_IO = 4'h6;
  localparam logic [11:0] ADDR_RUN = 12'h140;
  localparam logic [11:0] ADDR_LOCK = 12'h144;
  localparam logic [11:0] ADDR_STATUS = 12'h148;
  localparam logic [11:0] ADDR_CLEAR = 12'h14C;
  localparam logic [11:0] ADDR_ENABLE = 12'h150;
  // channel control fields
  localparam int CTRL_W = 9;
  localparam int CTRL_CAP_LSB = 0;
  localparam int CTRL_BUF_AC = 4;
  localparam int CTRL_BUF_BD = 5;
  localparam int CTRL_CLR_LSB = 6;
  typedef enum logic [2:0] {
    MCT_CLR_NONE, MCT_CLR_A, MCT_CLR_B, MCT_CLR_C, MCT_CLR_D, MCT_CLR_SYNC
  } mct_clr_t;
  function automatic int run_pos(input int ch);
    return (ch < 3) ? ch : ch + 3;
  endfunction
  function automatic bit has_cd(input int ch);
    return (ch == 0) || (ch >= 3);
  endfunction
endpackage
`default_nettype wire

// ---- hw/mct_channel.sv ----
// one timer channel: counter, compare/capture values, buffers and pins
`timescale 1ns/1ps
`default_nettype none
module mct_channel #(
  parameter int CNT_W = 16,
  parameter bit HAS_CD = 1'b1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // control
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [CNT_W-1:0] wdata_in,
  input wire logic [3:0] reg_wr_in,
  input wire logic [3:0] cap_mode_in,
  input wire logic buf_ac_in,
  input wire logic buf_bd_in,
  input wire logic [2:0] clr_sel_in,
  input wire logic sync_clear_in,
  input wire logic io_wr_in,
  input wire logic [3:0] init_level_in,
  input wire logic [3:0] pin_in,
  // state
  output logic [CNT_W-1:0] count_out,
  output logic [3:0][CNT_W-1:0] cc_out,
  output logic [3:0] event_out,
  output logic own_clear_out,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n_out
);
  logic [3:0] valid;
  logic [3:0] active;
  logic [3:0] pin_prev;
  logic [3:0] cap_evt;
  logic [3:0] match;
  logic buf_a;
  logic buf_b;

  // C and D exist only on four-value channels
  assign valid = HAS_CD ? 4'hF : 4'h3;
  // buffered C/D act for A/B only
  assign buf_a = HAS_CD && buf_ac_in;
  assign buf_b = HAS_CD && buf_bd_in;
  assign active = valid & {~buf_b, ~buf_a, 2'b11};
  assign cap_evt = active & cap_mode_in & pin_in & ~pin_prev;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      match[i] = active[i] && !cap_mode_in[i] && run_in && (count_out == cc_out[i]);
    end
  end
  assign event_out = cap_evt | match;
  always_comb begin
    own_clear_out = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (int'(clr_sel_in) == int'(mct_pkg::MCT_CLR_A) + i) begin
        own_clear_out = event_out[i];
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_prev <= 4'h0;
    end else if (ce_in) begin
      pin_prev <= pin_in;
    end
  end

  // counter: preset over clear over count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= mct_pkg::CNT_RESET;
    end else if (ce_in) begin
      if (load_in) begin
        count_out <= wdata_in;
      end else if (own_clear_out || sync_clear_in) begin
        count_out <= mct_pkg::CNT_RESET;
      end else if (run_in) begin
        count_out <= count_out + 1'b1;
      end
    end
  end

  // values start at all ones; a capture beats a write in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cc_out <= {4{mct_pkg::CC_RESET}};
    end else if (ce_in) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_wr_in[i] && valid[i]) begin
          cc_out[i] <= wdata_in;
        end
      end
      // buffer transfer on capture or match
      if (cap_evt[0]) begin
        cc_out[0] <= count_out;
        if (buf_a) cc_out[2] <= cc_out[0];
      end else if (match[0] && buf_a) begin
        cc_out[0] <= cc_out[2];
      end
      if (cap_evt[1]) begin
        cc_out[1] <= count_out;
        if (buf_b) cc_out[3] <= cc_out[1];
      end else if (match[1] && buf_b) begin
        cc_out[1] <= cc_out[3];
      end
      if (cap_evt[2]) cc_out[2] <= count_out;
      if (cap_evt[3]) cc_out[3] <= count_out;
    end
  end

  // toggle on match only while running, so a stop keeps the level
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out <= 4'h0;
      pin_oe_n_out <= 4'hF;
    end else if (ce_in) begin
      pin_oe_n_out <= ~(valid & ~cap_mode_in);
      // initial level on a stopped channel
      if (io_wr_in && !run_in) begin
        pin_out <= init_level_in & valid;
      end else begin
        pin_out <= pin_out ^ (match & valid);
      end
    end
  end

  pin_init_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && io_wr_in && !run_in |=> pin_out == ($past(init_level_in) & valid))
    else $error("pin did not take initial level");
  capture_copy_a: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && cap_evt[0] |=> cc_out[0] == $past(count_out))
    else $error("capture did not copy counter");
endmodule // mct_channel
`default_nettype wire

// ---- verification/tb_multichan_timer_run_sync_compare.sv ----
// self-checking bench for the five-channel compare/capture timer
`timescale 1ns/1ps
`default_nettype none
module tb_multichan_timer_run_sync_compare;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel_in = 1'b0;
  logic hwrite_in = 1'b0;
  logic [11:0] haddr_in = 12'h000;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h00000000;
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  logic irq_out;
  logic [19:0] pin_in = 20'h00000;
  logic [19:0] pin_out;
  logic [19:0] pin_oe_n_out;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  logic [31:0] mdl [int];
  logic [31:0] rd;
  logic [31:0] c;
  logic [31:0] seed = 32'h45202D89;

  mct_top mct_top_inst (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hready_in(hreadyout_out),
    .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n_out), .irq_out(irq_out)
  );

  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // writable bits of each word; reserved and absent places hold nothing
  function automatic logic [31:0] msk(input logic [11:0] a);
    int ch;
    int ix;
    ch = a[8:6];
    ix = a[5:2];
    if (a == 12'h140 || a == 12'h144) return 32'h000000C7;
    if (a == 12'h150) return 32'h000FFFFF;
    if (a >= 12'h140) return 32'h00000000;
    if (ix <= 4) return (ix >= 3 && (ch == 1 || ch == 2)) ? 32'h0 : 32'h0000FFFF;
    if (ix == 5) return 32'h000001FF;
    if (ix == 6) return 32'h0000000F;
    return 32'h00000000;
  endfunction

  function automatic logic [31:0] ev(input logic [11:0] a);
    if (mdl.exists(a)) return mdl[a];
    if (a < 12'h140 && a[5:2] >= 4'h1 && a[5:2] <= 4'h4 && msk(a) != 0) return 32'h0000FFFF;
    return 32'h00000000;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single transfer; hready is sampled at each rising edge
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [2:0] sz);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    hsize_in <= sz;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
    if (w && sz == 3'h2) mdl[a] = d & msk(a);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 3'h2);
  endtask

  task automatic rchk(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0, 3'h2);
    chk(rd, ev(a));
    chk({31'h0, hresp_out}, 32'h0);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    tick(3);
    chk({12'h000, pin_oe_n_out}, 32'h00000CC0);
    for (int ch = 0; ch < 5; ch++) begin
      for (int ix = 0; ix < 7; ix++) begin
        rchk(12'(ch * 64 + ix * 4));
      end
    end
    rchk(12'h140);
    rchk(12'h144);
    rchk(12'h148);
    rchk(12'h150);
    $display("test reset values done");

    // large values keep the short runs below clear of any match
    for (int ch = 0; ch < 5; ch++) begin
      for (int ix = 1; ix < 5; ix++) begin
        seed = lfsr(seed);
        wr(12'(ch * 64 + ix * 4), seed | 32'h00008000);
        rchk(12'(ch * 64 + ix * 4));
      end
    end
    xfer(12'h004, 1'b1, 32'h00001111, 3'h0);
    rchk(12'h004);
    wr(12'h1F0, 32'hFFFFFFFF);
    rchk(12'h1F0);
    wr(12'h148, 32'hFFFFFFFF);
    rchk(12'h148);
    $display("test register access done");

    wr(12'h140, 32'h000000FF);
    rchk(12'h140);
    tick(10);
    wr(12'h140, 32'h00000000);
    xfer(12'h0C0, 1'b0, 32'h0, 3'h2);
    c = rd;
    chk({31'h0, c != 0}, 32'h1);
    tick(10);
    xfer(12'h0C0, 1'b0, 32'h0, 3'h2);
    chk(rd, c);
    $display("test run control done");

    wr(12'h040, 32'h00000055);
    wr(12'h144, 32'h00000041);
    rchk(12'h144);
    seed = lfsr(seed);
    wr(12'h000, seed);
    xfer(12'h0C0, 1'b0, 32'h0, 3'h2);
    chk(rd, seed & 32'h0000FFFF);
    xfer(12'h040, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h00000055);
    $display("test lockstep preset done");

    wr(12'h040, 32'h00000000);
    wr(12'h044, 32'h00000005);
    wr(12'h150, 32'h00000010);
    wr(12'h140, 32'h00000002);
    n = 0;
    while (irq_out !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    chk({31'h0, irq_out}, 32'h1);
    wr(12'h140, 32'h00000000);
    chk({31'h0, pin_out[4]}, 32'h1);
    tick(20);
    chk({31'h0, pin_out[4]}, 32'h1);
    xfer(12'h148, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h00000010);
    wr(12'h150, 32'h00000000);
    tick(2);
    chk({31'h0, irq_out}, 32'h0);
    wr(12'h150, 32'h00000010);
    tick(2);
    chk({31'h0, irq_out}, 32'h1);
    wr(12'h14C, 32'h00000010);
    tick(2);
    chk({31'h0, irq_out}, 32'h0);
    rchk(12'h148);
    wr(12'h058, 32'h00000000);
    tick(2);
    chk({31'h0, pin_out[4]}, 32'h0);
    $display("test compare and interrupt done");

    wr(12'h094, 32'h00000001);
    wr(12'h080, 32'h00001234);
    @(posedge clk_in);
    pin_in[8] <= 1'b1;
    tick(8);
    pin_in[8] <= 1'b0;
    mdl[12'h084] = 32'h00001234;
    rchk(12'h084);
    xfer(12'h148, 1'b0, 32'h0, 3'h2);
    chk(rd, 32'h00000100);
    $display("test capture done");

    // channels stay halted while control words change
    wr(12'h144, 32'h00000000);
    wr(12'h000, 32'h00000000);
    wr(12'h0C0, 32'h00000064);
    wr(12'h014, 32'h00000040);
    wr(12'h0D4, 32'h00000140);
    wr(12'h004, 32'h00000003);
    // lockstep bits, then run bits, for channels 0 and 3
    wr(12'h144, 32'h00000041);
    wr(12'h140, 32'h00000041);
    tick(20);
    wr(12'h140, 32'h00000000);
    xfer(12'h0C0, 1'b0, 32'h0, 3'h2);
    chk({31'h0, rd < 4}, 32'h1);
    $display("test lockstep clear done");

    wr(12'h114, 32'h00000010);
    wr(12'h10C, 32'h00000009);
    wr(12'h104, 32'h00000002);
    wr(12'h100, 32'h00000000);
    wr(12'h140, 32'h00000080);
    tick(10);
    wr(12'h140, 32'h00000000);
    mdl[12'h104] = 32'h00000009;
    rchk(12'h104);
    $display("test buffer transfer done");
    close_out();
  end
endmodule // tb_multichan_timer_run_sync_compare
`default_nettype wire
